// *** verif/trh_link_assertions.sv ***
// Port checker for the trigger handshake link
`timescale 1ns/1ps
`default_nettype none
module trh_link_chk (
  // Clock, reset, bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Lines and engine
  input wire logic [5:0] line_out,
  input wire logic [5:0] line_oe,
  input wire logic meas_start,
  input wire logic meas_done
);
  // ----
  // Shadow config and pulse length
  // ----
  logic wr_ph;
  logic [31:0] cfg;
  logic [9:0] run;
  wire [2:0] o = cfg[10:8] - 3'h1;
  wire [2:0] s = cfg[14:12] - 3'h1;
  // Refused async settings never reach the shadow, as in the device
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_ph <= 1'b0;
      cfg <= trh_pkg::RST_CTRL;
    end
    else
    begin
      wr_ph <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == trh_pkg::OFS_CTRL;
      if (wr_ph && (hwdata[3] || hwdata[6:4] != hwdata[10:8]))
        cfg <= hwdata;
    end
  // Cycles the output line has been pulled so far
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      run <= 10'h000;
    else
      run <= line_oe[o] ? run + 10'h001 : 10'h000;
  // ----
  // Properties
  // ----
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence src_pull;
    line_oe[s] [*8];
  endsequence
  okay_resp_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not OKAY");
  drive_low_a: assert property (line_out == 6'h00)
    else $error("line driven high");
  start_single_a: assert property (meas_start |=> !meas_start)
    else $error("start longer than one cycle");
  async_lines_a: assert property (!cfg[3] |-> ((line_oe & ~$past(line_oe)) & ~(6'h01 << o)) == 6'h00)
    else $error("async pull on a line other than output");
  pulse_len_a: assert property (!cfg[3] && $stable(o) && $fell(line_oe[o]) |-> run == 10'(trh_pkg::PULSE_CYC))
    else $error("output pulse length wrong");
  semi_hold_a: assert property (cfg[3] && cfg[18] && !cfg[22] && meas_start |=> line_oe[s])
    else $error("acceptor not holding line at start");
  hold_busy_a: assert property (cfg[3] && !cfg[22] && line_oe[s] && !meas_done && !$past(meas_done) |=> line_oe[s])
    else $error("acceptor let go while busy");
  release_a: assert property (cfg[3] && !cfg[22] && meas_done |-> ##[1:2] !line_oe[s])
    else $error("acceptor kept line after done");
  src_pull_a: assert property (cfg[3] && cfg[22] && $rose(line_oe[s]) |-> src_pull)
    else $error("source pull too short");
endmodule // trh_link_chk
bind trh_link trh_link_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .line_out, .line_oe, .meas_start, .meas_done);
`default_nettype wire

// *** verif/trh_link_bench.sv ***
// Self-checking bench for the trigger handshake link
`timescale 1ns/1ps
`default_nettype none
module trh_link_bench;
  // ----
  // Signals
  // ----
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, meas_start, go, acc;
  logic meas_done = 1'b0;
  logic [1:0] htrans;
  logic [2:0] hsize, ln;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [5:0] line_out, line_oe, p_oe;
  logic [15:0] len;
  int md = 0;
  int n, s;
  int num_errors = 0;
  int n_tests = 0;
  // Pull-up: a line is low while anyone pulls it
  wire [5:0] line = ~(line_oe | p_oe);
  trh_link uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .line_in(line), .line_out, .line_oe, .meas_start, .meas_done);
  trh_peer peer (.hclk, .go, .acc, .ln, .len, .line, .oe(p_oe));
  // Clock, 25 ns period
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Measurement engine: each reading ends after a random settle
  always @(posedge hclk)
  begin
    meas_done <= (md == 1);
    if (meas_start === 1'b1)
      md <= 2 + $urandom % 20;
    else if (md > 0)
      md <= md - 1;
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // One AHB-Lite single word transfer; waits on ready, never on a count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic kick(input logic [2:0] l, input logic [15:0] t);
    ln <= l;
    len <= t;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
  endtask
  task automatic wstart(input int lim);
    n = 0;
    while (meas_start !== 1'b1 && n < lim)
    begin
      @(posedge hclk);
      n++;
    end
  endtask
  // Length of the next low spell, and starts seen during it
  task automatic low_len(input int b);
    n = 0;
    s = 0;
    while (line[b] !== 1'b0) @(posedge hclk);
    while (line[b] === 1'b0)
    begin
      s += meas_start;
      n++;
      @(posedge hclk);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog, far beyond the few thousand cycles needed
  initial
  begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    end_sim();
  end
  // ----
  // Scenarios
  // ----
  initial
  begin
    void'($urandom(26360));
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    go = 1'b0;
    acc = 1'b0;
    ln = 3'h0;
    len = 16'h0002;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, trh_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", trh_pkg::RST_CTRL, rd);
    bus(1'b0, trh_pkg::OFS_ARM_CNT, 32'h0);
    chk("arm", 32'h1, rd);
    bus(1'b0, trh_pkg::OFS_SCAN_CNT, 32'h0);
    chk("scan", 32'h0, rd);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    // Same line for input and output is dropped whole
    bus(1'b1, trh_pkg::OFS_CTRL, 32'h0004_1551);
    bus(1'b0, trh_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", trh_pkg::RST_CTRL, rd);
    bus(1'b0, trh_pkg::OFS_STATUS, 32'h0);
    chk("refused", 32'h1, rd[4]);
    // Defaults keep measuring; switch lines just after a start so no pulse is cut short
    wstart(2000);
    chk("running", 32'h1, n < 2000);
    // Async, in line 3 and out line 4; arm and scan immediate
    bus(1'b1, trh_pkg::OFS_CTRL, 32'h0004_1431);
    bus(1'b0, trh_pkg::OFS_STATUS, 32'h0);
    for (int i = 0; i < 400 && rd[3:0] !== 4'h3; i++)
      bus(1'b0, trh_pkg::OFS_STATUS, 32'h0);
    chk("state", 32'h3, rd[3:0]);
    repeat (4)
    begin
      kick(3'h2, 16'($urandom_range(30, 2)));
      wstart(40);
      chk("start", 32'h1, n < 40);
      low_len(3);
      chk("pulse", trh_pkg::PULSE_CYC, n);
    end
    // Semi-sync acceptor on line 1; the peer holds longer than we do
    bus(1'b1, trh_pkg::OFS_CTRL, 32'h0004_1129);
    kick(3'h0, 16'h003C);
    wstart(40);
    chk("start", 32'h1, n < 40);
    // The hold is registered one cycle behind the start strobe
    @(posedge hclk);
    chk("hold", 32'h1, line_oe[0]);
    while (meas_done !== 1'b1) @(posedge hclk);
    repeat (3) @(posedge hclk);
    chk("release", 32'h0, line_oe[0]);
    chk("wired", 32'h0, line[0]);
    while (line[0] !== 1'b1) @(posedge hclk);
    // Semi-sync source: stop, then restart so the first pass skips the wait
    bus(1'b1, trh_pkg::OFS_CTRL, 32'h0044_112C);
    acc <= 1'b1;
    len <= 16'h0258;
    bus(1'b1, trh_pkg::OFS_CTRL, 32'h0044_1129);
    wstart(40);
    chk("bypass", 32'h1, n < 40);
    low_len(0);
    chk("early", 32'h0, s);
    chk("held", 32'h1, n > 600);
    wstart(10);
    acc <= 1'b0;
    chk("rise", 32'h1, n < 10);
    low_len(0);
    chk("pull", trh_pkg::PULSE_CYC, n);
    end_sim();
  end
endmodule // trh_link_bench
`default_nettype wire

// *** verif/trh_peer.sv ***
// Another instrument on the trigger bus lines
`timescale 1ns/1ps
`default_nettype none
module trh_peer (
  // Clock
  input wire logic hclk,
  // Bench commands
  input wire logic go,
  input wire logic acc,
  input wire logic [2:0] ln,
  input wire logic [15:0] len,
  // Wired levels and our pull-downs
  input wire logic [5:0] line,
  output logic [5:0] oe
);
  // ----
  // Pull-down timer
  // ----
  logic [15:0] left = 16'h0000;
  logic last = 1'b1;
  // A command, or as acceptor a falling edge, starts a hold of len cycles
  always_ff @(posedge hclk)
  begin
    last <= line[ln];
    if (go || (acc && last && !line[ln]))
      left <= len;
    else if (left != 16'h0000)
      left <= left - 16'h0001;
  end
  // Only pull low or let go; the pull-up sets the idle level
  assign oe = (left != 16'h0000) ? 6'h01 << ln : 6'h00;
endmodule // trh_peer
`default_nettype wire

// *** verilog/trh_link.sv ***
// Trigger handshake link: AHB-Lite registers, layer sequencer, bus lines
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module trh_link #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Trigger bus lines, open drain
  input wire logic [5:0] line_in,
  output logic [5:0] line_out,
  output logic [5:0] line_oe,
  // Measurement engine handshake
  output logic meas_start,
  input wire logic meas_done
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Line number 1..6 to one-hot mask; other numbers select nothing
  function automatic logic [5:0] ln_mask(input logic [2:0] n);
    logic [5:0] m;
    m = 6'h00;
    if (n >= 3'd1 && n <= 3'd6)
      m = 6'h01 << (n - 3'd1);
    return m;
  endfunction

  // Count reached; zero programs an endless layer
  function automatic logic cnt_done(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] lim);
    return (lim != '0) && (c + 1'b1 >= lim);
  endfunction

  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  trh_pkg::trh_cfg_s cfg;
  logic [CNT_W-1:0] lim_arm;
  logic [CNT_W-1:0] lim_scan;
  logic [CNT_W-1:0] lim_meas;
  logic [CNT_W-1:0] c_arm;
  logic [CNT_W-1:0] c_scan;
  logic [CNT_W-1:0] c_meas;
  trh_pkg::trh_state_e st;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic init_req;
  logic abort_req;
  logic cfg_rej;
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] prev;
  logic [5:0] fall;
  logic [5:0] rise;
  logic [8:0] p_cnt;
  logic hold_low;
  logic [trh_pkg::NL-1:0] first;
  logic [CNT_W-1:0] wcnt;

  assign wcnt = hwdata[CNT_W-1:0];

  // Address phase capture; every access is zero wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend <= hsel && htrans[1] && hwrite && hready;
      wr_addr <= haddr[7:0];
    end
  end

  // Read data registered in the address phase for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hsel && htrans[1] && !hwrite && hready)
    begin
      case (haddr[7:0])
        trh_pkg::OFS_CTRL:
          hrdata <= {9'h000, cfg.ctl_src, 1'b0, cfg.src_bus, 1'b0, cfg.shr_ln,
                     1'b0, cfg.out_ln, 1'b0, cfg.in_ln, cfg.semi, 2'b00, cfg.cont};
        trh_pkg::OFS_ARM_CNT: hrdata <= 32'(lim_arm);
        trh_pkg::OFS_SCAN_CNT: hrdata <= 32'(lim_scan);
        trh_pkg::OFS_MEAS_CNT: hrdata <= 32'(lim_meas);
        trh_pkg::OFS_STATUS:
          hrdata <= {14'h0000, 6'(sync2), 7'h00, cfg_rej, 4'(st)};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration writes; an async pair on one line is refused whole
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg <= trh_pkg::trh_cfg_s'({trh_pkg::RST_CTRL[trh_pkg::B_CONT], trh_pkg::RST_CTRL[trh_pkg::B_SEMI],
                         trh_pkg::RST_CTRL[trh_pkg::F_IN +: trh_pkg::LN_W],
                         trh_pkg::RST_CTRL[trh_pkg::F_OUT +: trh_pkg::LN_W],
                         trh_pkg::RST_CTRL[trh_pkg::F_SHR +: trh_pkg::LN_W],
                         trh_pkg::RST_CTRL[trh_pkg::F_SRC +: trh_pkg::NL],
                         trh_pkg::RST_CTRL[trh_pkg::F_CTL +: trh_pkg::NL]});
      lim_arm <= CNT_W'(trh_pkg::RST_ARM_CNT);
      lim_scan <= CNT_W'(trh_pkg::RST_INF_CNT);
      lim_meas <= CNT_W'(trh_pkg::RST_INF_CNT);
      cfg_rej <= 1'b0;
    end
    else if (wr_pend)
    begin
      case (wr_addr)
        trh_pkg::OFS_CTRL:
        begin
          if (!hwdata[trh_pkg::B_SEMI] &&
              (hwdata[trh_pkg::F_IN +: trh_pkg::LN_W] == hwdata[trh_pkg::F_OUT +: trh_pkg::LN_W]))
            cfg_rej <= 1'b1;
          else
          begin
            cfg_rej <= 1'b0;
            cfg.cont <= hwdata[trh_pkg::B_CONT];
            cfg.semi <= hwdata[trh_pkg::B_SEMI];
            cfg.in_ln <= hwdata[trh_pkg::F_IN +: trh_pkg::LN_W];
            cfg.out_ln <= hwdata[trh_pkg::F_OUT +: trh_pkg::LN_W];
            cfg.shr_ln <= hwdata[trh_pkg::F_SHR +: trh_pkg::LN_W];
            cfg.src_bus <= hwdata[trh_pkg::F_SRC +: trh_pkg::NL];
            cfg.ctl_src <= hwdata[trh_pkg::F_CTL +: trh_pkg::NL];
          end
        end
        trh_pkg::OFS_ARM_CNT: lim_arm <= wcnt;
        trh_pkg::OFS_SCAN_CNT: lim_scan <= wcnt;
        trh_pkg::OFS_MEAS_CNT: lim_meas <= wcnt;
        default: ;
      endcase
    end
  end

  // One-cycle command strobes from the control register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      init_req <= 1'b0;
      abort_req <= 1'b0;
    end
    else
    begin
      init_req <= wr_pend && (wr_addr == trh_pkg::OFS_CTRL) && hwdata[trh_pkg::B_INIT];
      abort_req <= wr_pend && (wr_addr == trh_pkg::OFS_CTRL) && hwdata[trh_pkg::B_ABORT];
    end
  end

  // ----------------------------------------------------------------
  // Bus line inputs
  // ----------------------------------------------------------------
  // Two sync flops and one history flop per line; edges compare the second stage with the history
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1 <= 6'h3F;
      sync2 <= 6'h3F;
      prev <= 6'h3F;
    end
    else
    begin
      sync1 <= line_in;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  assign fall = prev & ~sync2;
  assign rise = ~prev & sync2;

  // Trigger seen by the measure or upper layers this cycle
  logic bus_trig;
  always_comb
  begin
    bus_trig = 1'b0;
    if (!cfg.semi)
      bus_trig = |(fall & ln_mask(cfg.in_ln));
    else if (cfg.ctl_src[trh_pkg::L_MEAS])
      bus_trig = |(rise & ln_mask(cfg.shr_ln));
    else
      bus_trig = |(fall & ln_mask(cfg.shr_ln));
  end

  // A layer proceeds when immediate, bypassed once, or triggered
  function automatic logic go(input int l);
    return !cfg.src_bus[l] || (cfg.ctl_src[l] && first[l]) || bus_trig;
  endfunction

  // ----------------------------------------------------------------
  // Layer sequencer
  // ----------------------------------------------------------------
  // Arm, scan and measure layers nested, outermost first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= trh_pkg::ST_IDLE;
      first <= '0;
      c_arm <= '0;
      c_scan <= '0;
      c_meas <= '0;
    end
    else if (abort_req)
      st <= trh_pkg::ST_IDLE;
    else
    begin
      case (st)
        trh_pkg::ST_IDLE:
          if (cfg.cont || init_req)
          begin
            first[trh_pkg::L_ARM] <= 1'b1;
            c_arm <= '0;
            st <= trh_pkg::ST_ARM_W;
          end
        trh_pkg::ST_ARM_W:
          if (go(trh_pkg::L_ARM))
          begin
            first[trh_pkg::L_ARM] <= 1'b0;
            first[trh_pkg::L_SCAN] <= 1'b1;
            c_scan <= '0;
            st <= trh_pkg::ST_SCAN_W;
          end
        trh_pkg::ST_SCAN_W:
          if (go(trh_pkg::L_SCAN))
          begin
            first[trh_pkg::L_SCAN] <= 1'b0;
            first[trh_pkg::L_MEAS] <= 1'b1;
            c_meas <= '0;
            st <= trh_pkg::ST_MEAS_W;
          end
        trh_pkg::ST_MEAS_W:
          if (go(trh_pkg::L_MEAS))
          begin
            first[trh_pkg::L_MEAS] <= 1'b0;
            st <= trh_pkg::ST_MEASURE;
          end
        trh_pkg::ST_MEASURE:
          if (meas_done)
            st <= trh_pkg::ST_MEAS_OUT;
        trh_pkg::ST_MEAS_OUT:
          if (p_cnt == '0)
          begin
            c_meas <= c_meas + 1'b1;
            if (cnt_done(c_meas, lim_meas))
              st <= trh_pkg::ST_SCAN_OUT;
            else
              st <= trh_pkg::ST_MEAS_W;
          end
        trh_pkg::ST_SCAN_OUT:
          if (p_cnt == '0)
          begin
            c_scan <= c_scan + 1'b1;
            if (cnt_done(c_scan, lim_scan))
              st <= trh_pkg::ST_ARM_OUT;
            else
              st <= trh_pkg::ST_SCAN_W;
          end
        trh_pkg::ST_ARM_OUT:
          if (p_cnt == '0)
          begin
            c_arm <= c_arm + 1'b1;
            if (cnt_done(c_arm, lim_arm))
              st <= trh_pkg::ST_IDLE;
            else
              st <= trh_pkg::ST_ARM_W;
          end
        default: st <= trh_pkg::ST_IDLE;
      endcase
    end
  end

  // Start strobe to the measurement engine
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      meas_start <= 1'b0;
    else
      meas_start <= (st == trh_pkg::ST_MEAS_W) && go(trh_pkg::L_MEAS) && !abort_req;
  end

  // ----------------------------------------------------------------
  // Bus line outputs
  // ----------------------------------------------------------------
  // Pulse timer loaded on entry to each output state. Semi-sync
  // scan and arm ends, and acceptor measure ends, only re-enter the sequencer: a pulse there would be
  // taken as a trigger by every acceptor on the shared line.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      p_cnt <= '0;
    else if (st == trh_pkg::ST_MEASURE && meas_done)
      p_cnt <= (cfg.semi && !cfg.ctl_src[trh_pkg::L_MEAS]) ? '0 : 9'(trh_pkg::PULSE_CYC);
    else if (st == trh_pkg::ST_MEAS_OUT && p_cnt == '0)
      p_cnt <= cfg.semi ? '0 : 9'(trh_pkg::PULSE_CYC);
    else if (st == trh_pkg::ST_SCAN_OUT && p_cnt == '0)
      p_cnt <= cfg.semi ? '0 : 9'(trh_pkg::PULSE_CYC);
    else if (p_cnt != '0)
      p_cnt <= p_cnt - 1'b1;
  end

  // Acceptor hold from the falling edge until its reading is done
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hold_low <= 1'b0;
    else if (!cfg.semi || cfg.ctl_src[trh_pkg::L_MEAS] || abort_req)
      hold_low <= 1'b0;
    else if (st == trh_pkg::ST_MEAS_W && bus_trig)
      hold_low <= 1'b1;
    else if (st == trh_pkg::ST_MEASURE && meas_done)
      hold_low <= 1'b0;
  end

  // Line drive: pull low only, never drive high
  logic pulsing;
  logic [5:0] next_oe;
  assign pulsing = (st == trh_pkg::ST_MEAS_OUT || st == trh_pkg::ST_SCAN_OUT ||
                    st == trh_pkg::ST_ARM_OUT) && (p_cnt != '0);
  always_comb
  begin
    next_oe = 6'h00;
    if (cfg.semi)
    begin
      if (hold_low || (pulsing && st == trh_pkg::ST_MEAS_OUT))
        next_oe = ln_mask(cfg.shr_ln);
    end
    else if (pulsing)
      next_oe = ln_mask(cfg.out_ln);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      line_oe <= 6'h00;
      line_out <= 6'h00;
    end
    else
    begin
      line_oe <= next_oe;
      line_out <= 6'h00;
    end
  end

endmodule // trh_link
`default_nettype wire

// *** verilog/trh_pkg.sv ***
// Constants, types and register map for the trigger handshake link
// ------------------------------------------------------------------
// ------------------------------------------------------------------
package trh_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ARM_CNT = 8'h04;
  localparam logic [7:0] OFS_SCAN_CNT = 8'h08;
  localparam logic [7:0] OFS_MEAS_CNT = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Control register fields
  localparam int B_CONT = 0;
  localparam int B_INIT = 1;
  localparam int B_ABORT = 2;
  localparam int B_SEMI = 3;
  localparam int F_IN = 4;
  localparam int F_OUT = 8;
  localparam int F_SHR = 12;
  localparam int F_SRC = 16;
  localparam int F_CTL = 20;
  localparam int LN_W = 3;
  localparam int NL = 3;
  // Layer indices into the per-layer fields
  localparam int L_ARM = 0;
  localparam int L_SCAN = 1;
  localparam int L_MEAS = 2;
  // Reset values: continuous on, in #2, out #1, shared #1
  localparam logic [31:0] RST_CTRL = 32'h0000_1121;
  localparam logic [15:0] RST_ARM_CNT = 16'h0001;
  localparam logic [15:0] RST_INF_CNT = 16'h0000;
  // Output pulse width on the bus lines
  localparam int CLK_MHZ = 40;
  localparam int OUT_PULSE_NS = 10000;
  localparam int PULSE_CYC = (OUT_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int NLINES = 6;

  typedef struct packed {
    logic cont;
    logic semi;
    logic [LN_W-1:0] in_ln;
    logic [LN_W-1:0] out_ln;
    logic [LN_W-1:0] shr_ln;
    logic [NL-1:0] src_bus;
    logic [NL-1:0] ctl_src;
  } trh_cfg_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ARM_W, ST_SCAN_W, ST_MEAS_W, ST_MEASURE,
    ST_MEAS_OUT, ST_SCAN_OUT, ST_ARM_OUT
  } trh_state_e;
endpackage
